/* File: rtl/cpc_top.sv */
/*
 read protection configuration bytes with clear-only bits and a gated programmer read path.
 assumes bus master and programmer share clk; memory data arrive with their request.
*/
// Our own choice: strobed register access.
`timescale 1ns/1ps
// How it works
// - eight block bits, zero locks that block
// - small variants lack block bits four-seven
// - high byte bit 7 locks eeprom
// - high byte bit 6 locks boot block
// - high byte bits 5-0 read zero
// - lock bits reset to one, clear only
// - boot lock region follows size setting
// - size one gives 2 kW, zero 1 kW
module cpc_top
   import cpc_pkg::*;
#(
   parameter bit LARGE_MEMORY = 1'b1,
   parameter int BLOCK_SHIFT  = 14
)
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [21:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   input  wire logic        prog_rd,
   input  wire logic [21:0] prog_addr,
   input  wire logic        prog_is_eeprom,
   input  wire logic [7:0]  mem_data,
   output logic [7:0]       prog_rdata,
   output logic             prog_rvalid,
   output logic             prog_blocked
);
   // upper block bits exist only on large parts
   localparam logic [7:0] IMPL_MASK = LARGE_MEMORY ? 8'hff : 8'h0f;

   typedef enum {SEL_NONE, SEL_LOCK_LOW, SEL_LOCK_HIGH, SEL_BOOT_CFG} cpc_sel_type;

   // one decode shared by both strobes, so a read shows the byte a write would hit
   function automatic cpc_sel_type reg_select(input logic [21:0] a);
      cpc_sel_type s;
      case (a)
         CPC_LOCK_LOW_OFS:  s = SEL_LOCK_LOW;
         CPC_LOCK_HIGH_OFS: s = SEL_LOCK_HIGH;
         CPC_BOOT_CFG_OFS:  s = SEL_BOOT_CFG;
         default:           s = SEL_NONE;
      endcase
      return s;
   endfunction

   logic [7:0]       low_r;
   logic [7:0]       low_nxt;
   wire  logic [7:0] low_clr;
   logic             eep_r;
   logic             eep_nxt;
   logic             boot_r;
   logic             boot_nxt;
   logic             bsz_r;
   logic             bsz_nxt;

   logic [7:0]       rdata_r;
   logic [7:0]       rdata_nxt;

   logic [7:0]       pdata_r;
   logic [7:0]       pdata_nxt;
   logic             pval_r;
   logic             pval_nxt;
   logic             pblk_r;
   logic             pblk_nxt;
   logic             blocked;

   // lock bits: per-block clear requests
   // a bit falls only where a zero is written over an implemented block
   genvar gi;
   generate
      for (gi = 0; gi < CPC_BLOCKS; gi = gi + 1)
      begin : g_clr
         assign low_clr[gi] = ~reg_wdata[gi] & IMPL_MASK[gi];
      end
   endgenerate

   // lock bits: next value
   always_comb
   begin
      low_nxt  = low_r;
      eep_nxt  = eep_r;
      boot_nxt = boot_r;
      bsz_nxt  = bsz_r;
      if (reg_wr)
      begin
         case (reg_select(reg_addr))
            SEL_LOCK_LOW:
            begin
               // writing ones never restores a bit: erase is outside this block
               low_nxt = low_r & ~low_clr;
            end
            SEL_LOCK_HIGH:
            begin
               eep_nxt  = eep_r & reg_wdata[CPC_EEPROM_BIT];
               boot_nxt = boot_r & reg_wdata[CPC_BOOT_BIT];
            end
            SEL_BOOT_CFG:
            begin
               // the size bit is a plain setting, so it may go both ways
               bsz_nxt = reg_wdata[CPC_BOOT_SIZE_BIT];
            end
            default:
            begin
               low_nxt = low_r;
            end
         endcase
      end
   end

   // lock bits: registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         low_r  <= CPC_LOCK_LOW_RST;
         eep_r  <= CPC_LOCK_HIGH_RST[CPC_EEPROM_BIT];
         boot_r <= CPC_LOCK_HIGH_RST[CPC_BOOT_BIT];
         bsz_r  <= CPC_BOOT_SIZE_RST;
      end
      else
      begin
         low_r  <= low_nxt;
         eep_r  <= eep_nxt;
         boot_r <= boot_nxt;
         bsz_r  <= bsz_nxt;
      end
   end

   // register read data: one cycle after the strobe, zero otherwise
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (reg_rd)
      begin
         case (reg_select(reg_addr))
            SEL_LOCK_LOW:
            begin
               rdata_nxt = low_r & IMPL_MASK;
            end
            SEL_LOCK_HIGH:
            begin
               rdata_nxt                 = 8'h00;
               rdata_nxt[CPC_EEPROM_BIT] = eep_r;
               rdata_nxt[CPC_BOOT_BIT]   = boot_r;
            end
            SEL_BOOT_CFG:
            begin
               rdata_nxt                    = 8'h00;
               rdata_nxt[CPC_BOOT_SIZE_BIT] = bsz_r;
            end
            default:
            begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   // register read data: register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rdata_r <= 8'h00;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   cpc_region_gate #(.BLOCK_SHIFT(BLOCK_SHIFT)) u_gate (
      .addr             (prog_addr),
      .is_eeprom        (prog_is_eeprom),
      .block_unlock     (low_r | ~IMPL_MASK),
      .eeprom_unlock    (eep_r),
      .boot_unlock      (boot_r),
      .boot_size_select (bsz_r),
      .read_blocked     (blocked)
   );

   // programmer read: gated data one cycle after the request
   always_comb
   begin
      pval_nxt  = prog_rd;
      pblk_nxt  = 1'b0;
      pdata_nxt = 8'h00;
      if (prog_rd)
      begin
         if (blocked)
         begin
            // zeros with the blocked flag raised, so a locked part reveals nothing
            pblk_nxt  = 1'b1;
            pdata_nxt = 8'h00;
         end
         else
         begin
            pdata_nxt = mem_data;
         end
      end
   end

   // programmer read: registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pdata_r <= 8'h00;
         pval_r  <= 1'b0;
         pblk_r  <= 1'b0;
      end
      else
      begin
         pdata_r <= pdata_nxt;
         pval_r  <= pval_nxt;
         pblk_r  <= pblk_nxt;
      end
   end

   assign reg_rdata    = rdata_r;
   assign prog_rdata   = pdata_r;
   assign prog_rvalid  = pval_r;
   assign prog_blocked = pblk_r;
endmodule

/* File: inc/cpc_pkg.sv */
/*
 read protection configuration: register offsets, field positions, reset values.
 assumes byte-wide configuration space reached over a plain strobe port.
*/
package cpc_pkg;
   localparam logic [21:0] CPC_LOCK_LOW_OFS  = 22'h300008;
   localparam logic [21:0] CPC_LOCK_HIGH_OFS = 22'h300009;
   localparam logic [21:0] CPC_BOOT_CFG_OFS  = 22'h300006;
   localparam int          CPC_EEPROM_BIT    = 7;
   localparam int          CPC_BOOT_BIT      = 6;
   localparam int          CPC_BOOT_SIZE_BIT = 4;
   localparam logic [7:0]  CPC_LOCK_LOW_RST  = 8'hff;
   localparam logic [7:0]  CPC_LOCK_HIGH_RST = 8'hc0;
   localparam logic        CPC_BOOT_SIZE_RST = 1'b0;
   // boot block word counts for the two size settings
   localparam logic [21:0] CPC_BOOT_WORDS_1K = 22'h000400;
   localparam logic [21:0] CPC_BOOT_WORDS_2K = 22'h000800;
   localparam int          CPC_BLOCKS        = 8;
endpackage

/* File: rtl/cpc_region_gate.sv */
/*
 region lookup and read gate for program memory, eeprom and boot block.
 assumes a word address from the programmer, same clock domain.
*/
`timescale 1ns/1ps
module cpc_region_gate
   import cpc_pkg::*;
#(
   parameter int BLOCK_SHIFT = 14
)
(
   input  wire logic [21:0] addr,
   input  wire logic        is_eeprom,
   input  wire logic [7:0]  block_unlock,
   input  wire logic        eeprom_unlock,
   input  wire logic        boot_unlock,
   input  wire logic        boot_size_select,
   output logic             read_blocked
);
   logic [21:0] boot_words;
   logic [2:0]  blk;

   always_comb
   begin
      boot_words = boot_size_select ? CPC_BOOT_WORDS_2K : CPC_BOOT_WORDS_1K;
      blk        = addr[BLOCK_SHIFT +: 3];
      if (is_eeprom)
         read_blocked = ~eeprom_unlock;
      else if (addr < boot_words)
         read_blocked = ~boot_unlock;
      else
         read_blocked = ~block_unlock[blk];
   end
endmodule

/* File: sim/cpc_top_sva.sv */
/*
 checker on the cpc_top ports.
 assumes it is bound to cpc_top by the bench top.
*/
`timescale 1ns/1ps
module cpc_top_chk
   import cpc_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [21:0] reg_addr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        prog_rd,
   input wire logic [7:0]  mem_data,
   input wire logic [7:0]  prog_rdata,
   input wire logic        prog_rvalid,
   input wire logic        prog_blocked
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_rvalid_timing: assert property (prog_rd |=> prog_rvalid)
      else $error("rvalid late");
   a_rvalid_spurious: assert property (!prog_rd |=> !prog_rvalid)
      else $error("rvalid extra");
   a_blocked_zero: assert property (prog_blocked |-> prog_rvalid && prog_rdata == 8'h00)
      else $error("locked data out");
   a_open_passes: assert property (prog_rvalid && !prog_blocked |-> prog_rdata == $past(mem_data))
      else $error("open data lost");
   a_prog_idle: assert property (!prog_rvalid |-> prog_rdata == 8'h00 && !prog_blocked)
      else $error("prog idle");
   a_high_unimpl: assert property (reg_rd && reg_addr == CPC_LOCK_HIGH_OFS |=> reg_rdata[5:0] == 6'h00)
      else $error("high low bits");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("rdata idle");
   a_unmapped_zero: assert property (reg_rd && reg_addr > CPC_LOCK_HIGH_OFS |=> reg_rdata == 8'h00)
      else $error("unmapped read");
endmodule

/* File: sim/cpc_prog_model.sv */
/*
 programmer read model; the bench calls pread.
 assumes the same clock as the block.
*/
`timescale 1ns/1ps
module cpc_prog_model
(
   input  wire logic        clk,
   output logic             prog_rd = 1'b0,
   output logic [21:0]      prog_addr = 22'h0,
   output logic             prog_is_eeprom = 1'b0,
   output logic [7:0]       mem_data = 8'h0,
   input  wire logic [7:0]  prog_rdata,
   input  wire logic        prog_blocked
);
   task pread(input logic [21:0] a, input logic e, input logic [7:0] d,
              output logic [7:0] q, output logic b);
      @(posedge clk);
      prog_rd <= 1'b1;
      prog_addr <= a;
      prog_is_eeprom <= e;
      mem_data <= d;
      @(posedge clk);
      prog_rd <= 1'b0;
      mem_data <= ~d; // stale data must not look valid
      #1;
      q = prog_rdata;
      b = prog_blocked;
   endtask
endmodule

/* File: sim/test_cpc_top.sv */
/*
 bench for cpc_top: register and programmer read sequences.
 u_dut uses default parameters: large memory, 14-bit block shift; u_dut_small is the small variant.
*/
`timescale 1ns/1ps
bind cpc_top cpc_top_chk u_chk (.*);
module test_cpc_top
   import cpc_pkg::*;
;
   logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, prog_rd, prog_is_eeprom;
   logic        prog_rvalid, prog_blocked, b;
   logic [21:0] reg_addr = 22'h0, prog_addr;
   logic [7:0]  reg_wdata = 8'h0, reg_rdata, mem_data, prog_rdata, q;
   logic [7:0]  small_rdata, small_prdata;
   logic        small_prvalid, small_pblk;
   int          err_count = 0, cmp_count = 0;
   cpc_top u_dut (.*);
   cpc_top #(.LARGE_MEMORY(1'b0)) u_dut_small (
      .clk            (clk),
      .sys_rst        (sys_rst),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_rdata      (small_rdata),
      .prog_rd        (prog_rd),
      .prog_addr      (prog_addr),
      .prog_is_eeprom (prog_is_eeprom),
      .mem_data       (mem_data),
      .prog_rdata     (small_prdata),
      .prog_rvalid    (small_prvalid),
      .prog_blocked   (small_pblk)
   );
   cpc_prog_model u_prog (.*);
   always #20 clk = ~clk;
   task chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task wr(input logic [21:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [21:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   task pr(input logic [21:0] a, input logic e, input logic [7:0] d, input logic k);
      u_prog.pread(a, e, d, q, b);
      chk(q, k ? 8'h00 : d);
      chk({7'h00, b}, {7'h00, k});
      chk({7'h00, prog_rvalid}, 8'h01);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (500) @(posedge clk);
      err_count++;
      close_out;
   end
   initial
   begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(CPC_LOCK_LOW_OFS, 8'hff);
      chk(small_rdata, 8'h0f);
      rd(CPC_LOCK_HIGH_OFS, 8'hc0);
      rd(22'h30000f, 8'h00);
      $display("test reset done");
      pr(22'h00c000, 1'b0, 8'ha5, 1'b0);
      wr(CPC_LOCK_LOW_OFS, 8'hf7);
      wr(CPC_LOCK_LOW_OFS, 8'hff);
      rd(CPC_LOCK_LOW_OFS, 8'hf7);
      pr(22'h00c000, 1'b0, 8'ha5, 1'b1);
      pr(22'h008000, 1'b0, 8'h5a, 1'b0);
      $display("test block done");
      wr(CPC_LOCK_HIGH_OFS, 8'hbf);
      rd(CPC_LOCK_HIGH_OFS, 8'h80);
      pr(22'h0003ff, 1'b0, 8'h3c, 1'b1);
      pr(22'h000500, 1'b0, 8'h3c, 1'b0);
      wr(CPC_BOOT_CFG_OFS, 8'h10);
      rd(CPC_BOOT_CFG_OFS, 8'h10);
      pr(22'h000500, 1'b0, 8'h3c, 1'b1);
      pr(22'h000500, 1'b1, 8'h66, 1'b0);
      wr(CPC_LOCK_HIGH_OFS, 8'h7f);
      rd(CPC_LOCK_HIGH_OFS, 8'h00);
      pr(22'h000500, 1'b1, 8'h66, 1'b1);
      $display("test region done");
      wr(CPC_LOCK_LOW_OFS, 8'h00);
      rd(CPC_LOCK_LOW_OFS, 8'h00);
      chk(small_rdata, 8'h00);
      pr(22'h01c000, 1'b0, 8'h5a, 1'b1);
      chk(small_prdata, 8'h5a);
      chk({7'h00, small_pblk}, 8'h00);
      chk({7'h00, small_prvalid}, 8'h01);
      $display("test variant done");
      close_out;
   end
endmodule
